/* File: hw/ptt_consts.svh */
`ifndef PTT_CONSTS_SVH
`define PTT_CONSTS_SVH
// register byte offsets
`define PTT_OFS_MODE 8'h00
`define PTT_OFS_STATUS 8'h04
`define PTT_OFS_VALUE_CLR 8'h08
`define PTT_OFS_VALUE_IMG 8'h0c
`define PTT_OFS_IRQ_CLR 8'h10
`define PTT_OFS_IRQ_EN 8'h14
// mode register fields
`define PTT_MODE_LIMIT_LSB 0
`define PTT_MODE_ON_BIT 24
`define PTT_MODE_IEN_BIT 25
// value and image register fields
`define PTT_VAL_COUNT_LSB 0
`define PTT_VAL_TALLY_LSB 20
// status, clear and enable bit of the interval-reached flag
`define PTT_FLAG_BIT 0
// reset values
`define PTT_RST_LIMIT 20'hf_ffff
`define PTT_RST_IRQ_EN 1'b1
// time base: master clock divided by this figure
`define PTT_CLK_DIV 16
`endif

/* File: hw/ptt_pkg.sv */
`default_nettype none
package ptt_pkg;
  localparam int PTT_COUNT_W = 20;
  localparam int PTT_TALLY_W = 12;
  typedef logic [PTT_COUNT_W-1:0] ptt_count_t;
  typedef logic [PTT_TALLY_W-1:0] ptt_tally_t;
  typedef logic [3:0] ptt_presc_t;
  // whole state of the timer
  typedef struct packed {
    ptt_presc_t presc;
    ptt_count_t count;
    ptt_tally_t tally;
    ptt_count_t limit;
    logic timer_on;
    logic mode_ien;
    logic running;
    logic flag;
    logic irq_en;
    logic irq;
    logic [31:0] rdata;
  } ptt_state_s;
endpackage : ptt_pkg
`default_nettype wire

/* File: hw/ptt_timer.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ptt_consts.svh"
module ptt_timer
  import ptt_pkg::*;
#(
  parameter int CLK_DIV = `PTT_CLK_DIV
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic DEBUG_HALT_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic IRQ_O
);

  localparam ptt_presc_t PRESC_LAST = ptt_presc_t'(CLK_DIV - 1);

  logic rst_meta_q;
  logic rst_n_q;
  ptt_state_s st_q;
  ptt_state_s st_d;
  logic tick;
  logic wrap;
  logic wr_mode;
  logic rd_clr;
  logic rd_img;

  // reset release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // decoded bus strokes
  assign wr_mode = WR_I && (ADDR_I == `PTT_OFS_MODE);
  assign rd_clr = RD_I && (ADDR_I == `PTT_OFS_VALUE_CLR);
  assign rd_img = RD_I && (ADDR_I == `PTT_OFS_VALUE_IMG);

  // prescaler terminal count; frozen in debug so no tick is owed afterwards
  assign tick = (st_q.presc == PRESC_LAST) && !DEBUG_HALT_I;
  assign wrap = tick && st_q.running && (st_q.count == st_q.limit);

  // next state
  always_comb begin
    st_d = st_q;
    // divider idles in debug state
    if (!DEBUG_HALT_I) begin
      st_d.presc = tick ? '0 : st_q.presc + 4'h1;
    end
    // counting; limit + 1 ticks per interval since 0 is counted too
    if (tick && st_q.running) begin
      if (wrap) begin
        st_d.count = '0;
        st_d.tally = st_q.tally + 12'h001;
      end else begin
        st_d.count = st_q.count + 20'h0_0001;
      end
    end
    // the on-bit only reaches the counter while it rests at zero
    if (st_q.count == '0) begin
      st_d.running = st_q.timer_on;
    end
    // mode write touches only the settings, never the counters
    if (wr_mode) begin
      st_d.limit = WDATA_I[`PTT_MODE_LIMIT_LSB +: PTT_COUNT_W];
      st_d.timer_on = WDATA_I[`PTT_MODE_ON_BIT];
      st_d.mode_ien = WDATA_I[`PTT_MODE_IEN_BIT];
    end
    if (WR_I && (ADDR_I == `PTT_OFS_IRQ_EN)) begin
      st_d.irq_en = WDATA_I[`PTT_FLAG_BIT];
    end
    // acknowledge: a wrap in the same cycle survives as tally one, flag set
    if (rd_clr) begin
      st_d.tally = wrap ? 12'h001 : 12'h000;
      st_d.flag = 1'b0;
    end
    if (WR_I && (ADDR_I == `PTT_OFS_IRQ_CLR) && WDATA_I[`PTT_FLAG_BIT]) begin
      st_d.flag = 1'b0;
    end
    // set wins over either clear
    if (wrap) begin
      st_d.flag = 1'b1;
    end
    // level interrupt from next state so it tracks the flag with no lag
    st_d.irq = st_d.flag && st_d.mode_ien && st_d.irq_en;
    // read data stands only in the cycle after the strobe
    st_d.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        `PTT_OFS_MODE: begin
          st_d.rdata[`PTT_MODE_LIMIT_LSB +: PTT_COUNT_W] = st_q.limit;
          st_d.rdata[`PTT_MODE_ON_BIT] = st_q.timer_on;
          st_d.rdata[`PTT_MODE_IEN_BIT] = st_q.mode_ien;
        end
        `PTT_OFS_STATUS: begin
          st_d.rdata[`PTT_FLAG_BIT] = st_q.flag;
        end
        `PTT_OFS_VALUE_CLR, `PTT_OFS_VALUE_IMG: begin
          st_d.rdata[`PTT_VAL_COUNT_LSB +: PTT_COUNT_W] = st_q.count;
          st_d.rdata[`PTT_VAL_TALLY_LSB +: PTT_TALLY_W] = st_q.tally;
        end
        `PTT_OFS_IRQ_EN: begin
          st_d.rdata[`PTT_FLAG_BIT] = st_q.irq_en;
        end
        default: begin
          st_d.rdata = '0; // unmapped and write-only read as zero
        end
      endcase
    end
  end

  // state register; timer is off after reset
  always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= '0;
      st_q.limit <= `PTT_RST_LIMIT;
      st_q.irq_en <= `PTT_RST_IRQ_EN;
    end else begin
      st_q <= st_d;
    end
  end

  assign RDATA_O = st_q.rdata;
  assign IRQ_O = st_q.irq;

  // checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_wrap;
    st_q.running && tick && (st_q.count == st_q.limit);
  endsequence

  sequence s_quiet_ack;
    !rd_clr && !(WR_I && (ADDR_I == `PTT_OFS_IRQ_CLR));
  endsequence

  // stop after a wrap: counter rests at zero, then running drops a cycle later
  sequence s_stop;
    (st_q.count == '0) ##1 !st_q.running;
  endsequence

  property p_tick_only;
    !$stable(st_q.count) |-> $past(tick);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count moved without tick");

  property p_div16;
    tick ##1 !DEBUG_HALT_I [*8] |-> !tick;
  endproperty
  a_div16: assert property (p_div16) else $error("tick spacing too short");

  // a clearing read in the wrap cycle leaves a tally of one, never zero
  property p_wrap;
    s_wrap |=> (st_q.count == '0)
      && (st_q.tally == ($past(rd_clr) ? 12'h001 : $past(st_q.tally) + 12'h001));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not reset count");

  property p_flag;
    s_wrap |=> st_q.flag ##0 (IRQ_O == (st_q.mode_ien && st_q.irq_en));
  endproperty
  a_flag: assert property (p_flag) else $error("flag or irq missing after wrap");

  property p_irq;
    IRQ_O == (st_q.flag && st_q.mode_ien && st_q.irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level mismatch");

  property p_limit_write;
    wr_mode && !tick |=> $stable(st_q.count) && $stable(st_q.tally);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("mode write moved counters");

  property p_clear_read;
    rd_clr && !wrap |=> (st_q.tally == '0) && !st_q.flag;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clearing read left state");

  property p_image_read;
    ((rd_img && !tick) and s_quiet_ack) |=> $stable(st_q.tally) && $stable(st_q.flag);
  endproperty
  a_image_read: assert property (p_image_read) else $error("image read had effect");

  property p_value_layout;
    (rd_clr || rd_img) |=> RDATA_O == {$past(st_q.tally), $past(st_q.count)};
  endproperty
  a_value_layout: assert property (p_value_layout) else $error("value layout wrong");

  property p_stay_off;
    !st_q.running && !st_q.timer_on && (st_q.count == '0) |=> (st_q.count == '0) [*2];
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("stopped timer counted");

  property p_finish;
    st_q.running && (st_q.count != '0) |=> st_q.running;
  endproperty
  a_finish: assert property (p_finish) else $error("interval cut short");

  property p_debug;
    DEBUG_HALT_I |=> $stable(st_q.count) && $stable(st_q.presc);
  endproperty
  a_debug: assert property (p_debug) else $error("counted in debug");

  property p_status;
    RD_I && (ADDR_I == `PTT_OFS_STATUS) |=> RDATA_O == {31'h0, $past(st_q.flag)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  // the divider restarts from zero after every tick
  property p_presc_wrap;
    tick |=> (st_q.presc == '0);
  endproperty
  a_presc_wrap: assert property (p_presc_wrap) else $error("divider did not restart");

  // between ticks the divider steps by one each clock outside debug halt
  property p_presc_step;
    !DEBUG_HALT_I && !tick |=> (st_q.presc == $past(st_q.presc) + 4'h1);
  endproperty
  a_presc_step: assert property (p_presc_step) else $error("divider skipped a step");

  // below the limit a tick adds exactly one
  property p_count_step;
    tick && st_q.running && (st_q.count != st_q.limit) |=>
      (st_q.count == $past(st_q.count) + 20'h0_0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  // the tally moves only on a wrap or a clearing read
  property p_tally_hold;
    !wrap && !rd_clr |=> $stable(st_q.tally);
  endproperty
  a_tally_hold: assert property (p_tally_hold) else $error("tally moved on its own");

  // the flag is raised by nothing but a wrap
  property p_flag_rise;
    $rose(st_q.flag) |-> $past(wrap);
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without wrap");

  // a pending flag stays silent while the mode enable is low
  property p_irq_gate;
    !st_q.mode_ien |-> !IRQ_O;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while enable low");

  // the clearing read acknowledges the interrupt on the next edge
  property p_ack_irq;
    rd_clr && !wrap |=> !IRQ_O;
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("irq after clearing read");

  // a profiler reading the image must not disturb the count
  property p_image_count;
    rd_img && !tick |=> $stable(st_q.count);
  endproperty
  a_image_count: assert property (p_image_count) else $error("image read moved count");

  // the on-bit reaches the counter only while it rests at zero
  property p_on_at_zero;
    $changed(st_q.running) |-> ($past(st_q.count) == '0);
  endproperty
  a_on_at_zero: assert property (p_on_at_zero) else $error("on-bit acted off zero");

  // with the on-bit low, the wrap is the last step of the interval
  property p_stop_wrap;
    (!st_q.timer_on && !wr_mode) ##0 s_wrap |=> s_stop;
  endproperty
  a_stop_wrap: assert property (p_stop_wrap) else $error("ran on after stop");

  // a stopped timer holds its count
  property p_idle_count;
    !st_q.running |=> $stable(st_q.count);
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("stopped count moved");

  // no wrap can reach the tally while the core is halted
  property p_debug_tally;
    DEBUG_HALT_I && !rd_clr |=> $stable(st_q.tally);
  endproperty
  a_debug_tally: assert property (p_debug_tally) else $error("tally moved in debug");

  // a mode write loads all three settings together
  property p_mode_write;
    wr_mode |-> (st_d.limit == WDATA_I[`PTT_MODE_LIMIT_LSB +: PTT_COUNT_W])
      && (st_d.timer_on == WDATA_I[`PTT_MODE_ON_BIT])
      && (st_d.mode_ien == WDATA_I[`PTT_MODE_IEN_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost field");

  // mode reads back in its documented layout, spare bits zero
  property p_mode_read;
    RD_I && (ADDR_I == `PTT_OFS_MODE) |=>
      RDATA_O == {6'h00, $past(st_q.mode_ien), $past(st_q.timer_on), 4'h0, $past(st_q.limit)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

  // the flag is sticky until one of the two clear paths
  property p_flag_sticky;
    (st_q.flag and s_quiet_ack) |=> st_q.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

  // reading status is free of side effects
  property p_status_quiet;
    RD_I && (ADDR_I == `PTT_OFS_STATUS) && !tick |=>
      $stable(st_q.flag) && $stable(st_q.tally);
  endproperty
  a_status_quiet: assert property (p_status_quiet) else $error("status read effect");

  // the write-one clear drops flag and interrupt together
  property p_irq_clr;
    WR_I && (ADDR_I == `PTT_OFS_IRQ_CLR) && WDATA_I[`PTT_FLAG_BIT] && !wrap |=>
      !st_q.flag && !IRQ_O;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("clear write missed");

  // the enable register masks the level on the next edge
  property p_irq_en_off;
    WR_I && (ADDR_I == `PTT_OFS_IRQ_EN) && !WDATA_I[`PTT_FLAG_BIT] |=> !IRQ_O;
  endproperty
  a_irq_en_off: assert property (p_irq_en_off) else $error("irq with enable reg off");

endmodule : ptt_timer
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int DIV = 16;
  localparam int MAX_CYC = 20000;
  logic clk, rst_n, dbg, wr, rd, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, a, w;
  logic [19:0] lim;
  int n_fail = 0, checks = 0, cyc = 0, t1, t2;
  ptt_timer #(.CLK_DIV(DIV)) ptt_timer_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .DEBUG_HALT_I(dbg), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .IRQ_O(irq));
  // expected mode word: limit low, on bit 24, enable bit 25
  function automatic logic [31:0] mw(input logic [19:0] l, input logic on, input logic ien);
    return {6'h0, ien, on, 4'h0, l};
  endfunction : mw
  // one interval in master clocks
  function automatic int period(input logic [19:0] l);
    return DIV * (int'(l) + 1);
  endfunction : period
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic bus_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  // read data stand only in the cycle after the strobe; taken at the edge closing it
  task automatic bus_rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    addr <= ad; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : bus_rd
  // bounded wait for the interrupt level, longest interval well inside
  task automatic wait_irq();
    for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
    chk("irq seen", 32'h1, {31'h0, irq});
  endtask : wait_irq
  task automatic settle();
    @(posedge clk);
  endtask : settle
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    rst_n = 1'b0; dbg = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h0; wdata = 32'h0;
    void'($urandom(24847));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    bus_rd(8'h00, v); chk("mode rst", 32'h000f_ffff, v);
    bus_rd(8'h04, v); chk("status rst", 32'h0, v);
    bus_rd(8'h08, v); chk("value rst", 32'h0, v);
    bus_rd(8'h0c, v); chk("image rst", 32'h0, v);
    bus_rd(8'h20, v); chk("unmapped", 32'h0, v);
    bus_rd(8'h14, v); chk("en reg rst", 32'h1, v);
    // ascending limits so the count never lies above a new limit; zero first
    for (int i = 0; i < 4; i++) begin
      lim = (i == 0) ? 20'h0 : 20'(3 * i + $urandom % 3);
      bus_wr(8'h00, mw(lim, 1'b1, 1'b1));
      bus_rd(8'h00, v); chk("mode", mw(lim, 1'b1, 1'b1), v);
      wait_irq();
      bus_rd(8'h08, v);
      wait_irq(); t1 = cyc;
      bus_rd(8'h08, v); chk("value", 32'h0010_0000, v);
      chk("irq ack", 32'h0, {31'h0, irq});
      wait_irq(); t2 = cyc;
      chk("period", 32'(period(lim)), 32'(t2 - t1));
      bus_rd(8'h08, v);
    end
    wait_irq();
    bus_rd(8'h0c, a); bus_rd(8'h0c, v); chk("image tally", 32'h1, {20'h0, v[31:20]});
    bus_rd(8'h04, v); chk("status", 32'h1, v);
    chk("irq kept", 32'h1, {31'h0, irq});
    bus_wr(8'h00, mw(lim, 1'b1, 1'b0)); settle(); chk("ien off", 32'h0, {31'h0, irq});
    bus_wr(8'h00, mw(lim, 1'b1, 1'b1)); settle(); chk("ien on", 32'h1, {31'h0, irq});
    bus_wr(8'h14, 32'h0); settle(); chk("en reg", 32'h0, {31'h0, irq});
    bus_wr(8'h14, 32'h1); bus_wr(8'h10, 32'h1); settle();
    chk("irq clr", 32'h0, {31'h0, irq});
    bus_rd(8'h04, v); chk("status clr", 32'h0, v);
    // new limit mid-interval keeps both counters
    wait_irq(); repeat (3 * DIV) @(posedge clk);
    bus_rd(8'h0c, a); bus_wr(8'h00, mw(20'd200, 1'b1, 1'b1)); bus_rd(8'h0c, v);
    chk("tally kept", {20'h0, a[31:20]}, {20'h0, v[31:20]});
    chk("count kept", 32'h1, 32'(v[19:0] - a[19:0] <= 1 && a[19:0] != 0));
    dbg <= 1'b1;
    bus_rd(8'h0c, a); repeat (64) @(posedge clk); bus_rd(8'h0c, v);
    chk("debug halt", a, v);
    dbg <= 1'b0;
    // switched off: finishes the interval, wraps once, then stands at zero
    bus_wr(8'h00, mw(20'd200, 1'b0, 1'b1)); bus_rd(8'h0c, a);
    repeat (period(20'd200) + DIV) @(posedge clk);
    bus_rd(8'h0c, v); chk("off wrap", {a[31:20] + 12'h1, 20'h0}, v);
    repeat (64) @(posedge clk);
    bus_rd(8'h0c, w); chk("off stays", v, w);
    bus_wr(8'h00, mw(20'd200, 1'b1, 1'b1)); repeat (40) @(posedge clk);
    bus_rd(8'h0c, w); chk("restart", 32'h1, 32'(w[19:0] >= 20'h1));
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
